//--- pkg/bsl_regs.vh
// Constants of the serial boot loader: register map, field positions,
// byte codes, state codes and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef BSL_REGS_VH
`define BSL_REGS_VH

// ==========================================================
// Register byte addresses (AXI4-Lite, one word each)
`define BSL_OFF_CTRL 5'h00
`define BSL_OFF_BAUD 5'h04
`define BSL_OFF_STAT 5'h08
`define BSL_OFF_LEN 5'h0c
`define BSL_OFF_CNT 5'h10

// ==========================================================
// Control register fields
`define BSL_CTRL_RXEN 0
`define BSL_CTRL_TXEN 1
`define BSL_CTRL_PDIR 2
`define BSL_CTRL_POUT 3
`define BSL_CTRL_RST 4'h0

// ==========================================================
// Operating modes
`define BSL_MODE_NONE 2'h0
`define BSL_MODE_USER 2'h1
`define BSL_MODE_BOOT 2'h2
`define BSL_MODE_PROG 2'h3

// ==========================================================
// Link byte codes
`define BSL_CODE_ADJ 8'h00
`define BSL_CODE_SYNC 8'h55
`define BSL_CODE_OK 8'haa
`define BSL_CODE_ERR 8'hff

// ==========================================================
// Program window in on-chip RAM
`define BSL_RAM_BASE_N 24'h00f780
`define BSL_RAM_BASE_A 24'hfff780
`define BSL_RAM_SIZE 16'h0770

// ==========================================================
// Timing: start-up states before the low period is measured, low bits of the zero byte, shortest bit
`define BSL_STARTUP_STATES 8'h64
`define BSL_LOW_BITS 4'h9
`define BSL_MIN_BIT 16'h0002

// ==========================================================
// Sequencer states
`define BSL_S_OFF 5'h00
`define BSL_S_START 5'h01
`define BSL_S_IDLEHI 5'h02
`define BSL_S_FALL 5'h03
`define BSL_S_MEAS 5'h04
`define BSL_S_TXW 5'h05
`define BSL_S_SYNC 5'h06
`define BSL_S_CHK 5'h07
`define BSL_S_ERASE 5'h08
`define BSL_S_LENHI 5'h09
`define BSL_S_LENLO 5'h0a
`define BSL_S_DATA 5'h0b
`define BSL_S_NEXT 5'h0c
`define BSL_S_BRANCH 5'h0d
`define BSL_S_DONE 5'h0e
`define BSL_S_HALT 5'h0f

`endif

//--- rtl/bsl_top.v
// Serial boot loader with automatic bit-rate matching and an
// AXI4-Lite register slave.
// Assumes all inputs synchronous to mclk_i; flash erase and RAM are
// outside and answer on the plain ports below.
//
// Summary of operation
// - Straps select user, boot or programmer mode.
// - Link frame is 8N1, asynchronous.
// - Measure zero-byte low time, set divisor.
// - Wait 100 states before measuring.
// - Send zero byte, host replies 0x55.
// - Erase written flash, send 0xAA or 0xFF.
// - Two length bytes, high first, echoed.
// - Echo program bytes, store consecutively.
// - Send 0xAA, then branch to program.
// - Program window at 0xF780 or 0xFFF780.
// - Clear enables, keep divisor, drive pin high.
// - Watchdog overflow ends boot mode.
// - Supported host rates 9600 and 4800.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`include "bsl_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module bsl_top #(
  parameter ADV_ADDR = 0,
  parameter BAUD_W = 16
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire test_strap_i,
  input wire irq_strap_i,
  input wire boot_select_strap_i,
  input wire programmer_strap_0_i,
  input wire programmer_strap_1_i,
  input wire programmer_strap_2_i,
  input wire wdt_ovf_i,
  input wire rxd_i,
  output wire txd_o,
  output wire txd_oe_o,
  input wire flash_blank_i,
  input wire erase_done_i,
  input wire erase_fail_i,
  output reg erase_req_o,
  output reg ram_we_o,
  output reg [23:0] ram_addr_o,
  output reg [7:0] ram_wdata_o,
  output reg branch_o,
  output reg [23:0] branch_addr_o,
  output reg [1:0] mode_o,
  output wire boot_active_o,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [31:0] s_axi_araddr,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp
);

  localparam [23:0] RAM_BASE = (ADV_ADDR != 0) ? `BSL_RAM_BASE_A : `BSL_RAM_BASE_N;
  localparam [7:0] START_CYC = `BSL_STARTUP_STATES;

  reg [4:0] state;
  reg [4:0] ret_state;
  reg cap_pend;
  reg [7:0] wait_cnt;
  reg [BAUD_W-1:0] baud_divisor;
  reg [BAUD_W-1:0] bit_len;
  reg [3:0] sub9;
  reg [3:0] serial_control_reg;
  reg [15:0] prog_len;
  reg [15:0] byte_cnt;
  reg erase_err;
  reg tx_start;
  reg [7:0] tx_data;
  reg tx_busy;
  reg [9:0] tx_shift;
  reg [3:0] tx_bit;
  reg [BAUD_W-1:0] tx_cnt;
  reg rx_busy;
  reg [3:0] rx_bit;
  reg [BAUD_W-1:0] rx_cnt;
  reg [7:0] rx_shift;
  reg rx_valid;
  reg [7:0] rx_data;
  reg aw_got;
  reg w_got;
  reg [4:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire receive_enable_bit = serial_control_reg[`BSL_CTRL_RXEN];
  wire transmit_enable_bit = serial_control_reg[`BSL_CTRL_TXEN];
  wire transmit_pin_direction_bit = serial_control_reg[`BSL_CTRL_PDIR];
  wire transmit_pin_output_bit = serial_control_reg[`BSL_CTRL_POUT];
  // Sequencer owns the link from boot start until the branch
  wire seq_own = (state != `BSL_S_OFF) && (state != `BSL_S_DONE);
  wire sw_wr = aw_got && w_got && !s_axi_bvalid;
  // Receiver stays parked while the line is being timed
  wire rx_hold = (state == `BSL_S_START) || (state == `BSL_S_IDLEHI) ||
                 (state == `BSL_S_FALL) || (state == `BSL_S_MEAS);

  // Byte lane merge for software writes
  function [31:0] bsl_merge;
    input [31:0] old;
    input [31:0] din;
    input [3:0] strb;
    integer k;
    begin
      bsl_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          bsl_merge[k*8 +: 8] = din[k*8 +: 8];
        end
      end
    end
  endfunction

  // Merged words, cut down to the width each register really has
  wire [31:0] ctrl_merged = bsl_merge({28'h0, serial_control_reg}, w_data, w_strb);
  wire [31:0] baud_merged = bsl_merge({{(32-BAUD_W){1'b0}}, baud_divisor}, w_data, w_strb);

  assign boot_active_o = (mode_o == `BSL_MODE_BOOT) && seq_own;
  // Idle line rests on the pin output bit or the transmit enable bit, so the pin stays high after branch
  assign txd_o = tx_busy ? tx_shift[0] : (transmit_pin_output_bit | transmit_enable_bit);
  assign txd_oe_o = transmit_pin_direction_bit | transmit_enable_bit;

  // ==========================================================
  // Transmitter, LSB first, one start and one stop bit
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tx_busy <= 1'b0;
      tx_shift <= 10'h3ff;
      tx_bit <= 4'h0;
      tx_cnt <= {BAUD_W{1'b0}};
    end else if (!tx_busy) begin
      if (tx_start && transmit_enable_bit) begin
        tx_busy <= 1'b1;
        tx_shift <= {1'b1, tx_data, 1'b0};
        tx_bit <= 4'h0;
        tx_cnt <= baud_divisor - 1'b1;
      end
    end else if (tx_cnt != {BAUD_W{1'b0}}) begin
      tx_cnt <= tx_cnt - 1'b1;
    end else begin
      tx_cnt <= baud_divisor - 1'b1;
      tx_shift <= {1'b1, tx_shift[9:1]};
      tx_bit <= tx_bit + 4'h1;
      if (tx_bit == `BSL_LOW_BITS) begin
        tx_busy <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Receiver, samples mid-bit; frames with a low stop bit are dropped
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_busy <= 1'b0;
      rx_bit <= 4'h0;
      rx_cnt <= {BAUD_W{1'b0}};
      rx_shift <= 8'h00;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else if (rx_hold) begin
      // A frame caught with the reset divisor would keep the receiver
      // busy for hundreds of thousands of cycles and miss the sync byte
      rx_busy <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!rx_busy) begin
        if (receive_enable_bit && !rxd_i) begin
          rx_busy <= 1'b1;
          rx_bit <= 4'h0;
          rx_cnt <= {1'b0, baud_divisor[BAUD_W-1:1]};
        end
      end else if (rx_cnt != {BAUD_W{1'b0}}) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else begin
        rx_cnt <= baud_divisor - 1'b1;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0) begin
          rx_busy <= !rxd_i;
        end else if (rx_bit == `BSL_LOW_BITS) begin
          rx_busy <= 1'b0;
          rx_valid <= rxd_i;
          rx_data <= rx_shift;
        end else begin
          rx_shift <= {rxd_i, rx_shift[7:1]};
        end
      end
    end
  end

  // ==========================================================
  // Boot sequencer
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state <= `BSL_S_OFF;
      ret_state <= `BSL_S_OFF;
      cap_pend <= 1'b1;
      mode_o <= `BSL_MODE_NONE;
      wait_cnt <= 8'h00;
      baud_divisor <= {BAUD_W{1'b1}};
      bit_len <= {BAUD_W{1'b0}};
      sub9 <= 4'h0;
      serial_control_reg <= `BSL_CTRL_RST;
      prog_len <= 16'h0000;
      byte_cnt <= 16'h0000;
      erase_err <= 1'b0;
      erase_req_o <= 1'b0;
      tx_start <= 1'b0;
      tx_data <= 8'h00;
      ram_we_o <= 1'b0;
      ram_addr_o <= 24'h000000;
      ram_wdata_o <= 8'h00;
      branch_o <= 1'b0;
      branch_addr_o <= 24'h000000;
    end else begin
      tx_start <= 1'b0;
      ram_we_o <= 1'b0;
      branch_o <= 1'b0;
      cap_pend <= 1'b0;
      // Software may steer the port only when the sequencer lets go
      if (sw_wr && !seq_own && aw_addr == `BSL_OFF_CTRL) begin
        serial_control_reg <= ctrl_merged[3:0];
      end
      if (sw_wr && !seq_own && aw_addr == `BSL_OFF_BAUD) begin
        baud_divisor <= baud_merged[BAUD_W-1:0];
      end
      if (cap_pend) begin
        // straps settled before release, sampled once here
        if (!test_strap_i && irq_strap_i) begin
          mode_o <= `BSL_MODE_USER;
        end else if (!test_strap_i && boot_select_strap_i) begin
          mode_o <= `BSL_MODE_BOOT;
          state <= `BSL_S_START;
          serial_control_reg <= 4'hf;
        end else if (test_strap_i && !programmer_strap_0_i && !programmer_strap_1_i &&
                     !programmer_strap_2_i) begin
          mode_o <= `BSL_MODE_PROG;
        end
      end else if (wdt_ovf_i && seq_own) begin
        state <= `BSL_S_OFF;
        erase_req_o <= 1'b0;
        serial_control_reg <= `BSL_CTRL_RST;
      end else begin
        case (state)
          `BSL_S_OFF, `BSL_S_DONE, `BSL_S_HALT: begin
          end
          `BSL_S_START: begin
            wait_cnt <= wait_cnt + 8'h01;
            if (wait_cnt == START_CYC - 8'h01) begin
              state <= `BSL_S_IDLEHI;
            end
          end
          `BSL_S_IDLEHI: begin
            // insist on an idle line first
            if (rxd_i) begin
              state <= `BSL_S_FALL;
            end
          end
          `BSL_S_FALL: begin
            bit_len <= {BAUD_W{1'b0}};
            // The falling-edge sample is already the first low cycle of nine
            sub9 <= rxd_i ? 4'h0 : 4'h1;
            if (!rxd_i) begin
              state <= `BSL_S_MEAS;
            end
          end
          `BSL_S_MEAS: begin
            // nine cycles of low per divisor step
            if (rxd_i) begin
              if (bit_len < `BSL_MIN_BIT) begin
                state <= `BSL_S_FALL;
              end else begin
                baud_divisor <= bit_len;
                tx_data <= `BSL_CODE_ADJ;
                tx_start <= 1'b1;
                ret_state <= `BSL_S_SYNC;
                state <= `BSL_S_TXW;
              end
            end else if (sub9 == `BSL_LOW_BITS - 4'h1) begin
              sub9 <= 4'h0;
              bit_len <= bit_len + 1'b1;
            end else begin
              sub9 <= sub9 + 4'h1;
            end
          end
          `BSL_S_TXW: begin
            if (!tx_start && !tx_busy) begin
              state <= ret_state;
            end
          end
          `BSL_S_SYNC: begin
            // leftover zero bytes are skipped until 0x55
            if (rx_valid && rx_data == `BSL_CODE_SYNC) begin
              state <= `BSL_S_CHK;
            end
          end
          `BSL_S_CHK: begin
            // erase only when written data exists
            if (flash_blank_i) begin
              tx_data <= `BSL_CODE_OK;
              tx_start <= 1'b1;
              ret_state <= `BSL_S_LENHI;
              state <= `BSL_S_TXW;
            end else begin
              erase_req_o <= 1'b1;
              state <= `BSL_S_ERASE;
            end
          end
          `BSL_S_ERASE: begin
            if (erase_done_i) begin
              erase_req_o <= 1'b0;
              erase_err <= erase_fail_i;
              tx_data <= erase_fail_i ? `BSL_CODE_ERR : `BSL_CODE_OK;
              tx_start <= 1'b1;
              ret_state <= erase_fail_i ? `BSL_S_HALT : `BSL_S_LENHI;
              state <= `BSL_S_TXW;
            end
          end
          `BSL_S_LENHI, `BSL_S_LENLO: begin
            // length high byte first, each echoed
            if (rx_valid) begin
              if (state == `BSL_S_LENHI) begin
                prog_len[15:8] <= rx_data;
              end else begin
                prog_len[7:0] <= rx_data;
              end
              byte_cnt <= 16'h0000;
              tx_data <= rx_data;
              tx_start <= 1'b1;
              ret_state <= (state == `BSL_S_LENHI) ? `BSL_S_LENLO : `BSL_S_NEXT;
              state <= `BSL_S_TXW;
            end
          end
          `BSL_S_NEXT: begin
            if (byte_cnt == prog_len) begin
              tx_data <= `BSL_CODE_OK;
              tx_start <= 1'b1;
              ret_state <= `BSL_S_BRANCH;
              state <= `BSL_S_TXW;
            end else if (prog_len > `BSL_RAM_SIZE) begin
              // a program larger than the window is refused
              tx_data <= `BSL_CODE_ERR;
              tx_start <= 1'b1;
              ret_state <= `BSL_S_HALT;
              state <= `BSL_S_TXW;
            end else begin
              state <= `BSL_S_DATA;
            end
          end
          `BSL_S_DATA: begin
            if (rx_valid) begin
              // addresses count up from the window base
              ram_we_o <= 1'b1;
              ram_addr_o <= RAM_BASE + {8'h00, byte_cnt};
              ram_wdata_o <= rx_data;
              byte_cnt <= byte_cnt + 16'h0001;
              tx_data <= rx_data;
              tx_start <= 1'b1;
              ret_state <= `BSL_S_NEXT;
              state <= `BSL_S_TXW;
            end
          end
          `BSL_S_BRANCH: begin
            // enables off, divisor kept, pin driven high
            serial_control_reg <= 4'h0 | (4'h1 << `BSL_CTRL_PDIR) |
                                  (4'h1 << `BSL_CTRL_POUT);
            // hand execution to the loaded program
            // window released only from here on
            branch_o <= 1'b1;
            branch_addr_o <= RAM_BASE;
            state <= `BSL_S_DONE;
          end
          default: begin
            state <= `BSL_S_OFF;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // AXI4-Lite slave; address and data may arrive in either order
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr[4:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (sw_wr) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Writable words answer OKAY; the rest answer SLVERR
        s_axi_bresp <= (aw_addr == `BSL_OFF_CTRL || aw_addr == `BSL_OFF_BAUD) ?
                       2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read answer one cycle after the address is taken
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr[4:0])
        `BSL_OFF_CTRL: s_axi_rdata <= {28'h0, serial_control_reg};
        `BSL_OFF_BAUD: s_axi_rdata <= {{(32-BAUD_W){1'b0}}, baud_divisor};
        `BSL_OFF_STAT: s_axi_rdata <= {22'h0, erase_err, boot_active_o, mode_o,
                                       1'b0, state};
        `BSL_OFF_LEN: s_axi_rdata <= {16'h0, prog_len};
        `BSL_OFF_CNT: s_axi_rdata <= {16'h0, byte_cnt};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
      if (s_axi_araddr[31:5] != 27'h0) begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h2;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- dv/bsl_top_chk.sv
// Checker for the boot loader top: strap decode, RAM window, branch, erase.
// Assumes it is bound into bsl_top and that the shared header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "bsl_regs.vh"

// ==========================================================
// Port checker
module bsl_top_chk #(
  parameter ADV_ADDR = 0
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic test_strap_i,
  input wire logic irq_strap_i,
  input wire logic boot_select_strap_i,
  input wire logic programmer_strap_0_i,
  input wire logic programmer_strap_1_i,
  input wire logic programmer_strap_2_i,
  input wire logic wdt_ovf_i,
  input wire logic txd_o,
  input wire logic txd_oe_o,
  input wire logic erase_req_o,
  input wire logic erase_done_i,
  input wire logic ram_we_o,
  input wire logic [23:0] ram_addr_o,
  input wire logic branch_o,
  input wire logic [23:0] branch_addr_o,
  input wire logic [1:0] mode_o,
  input wire logic boot_active_o
);
  // Window base follows the addressing choice
  localparam logic [23:0] BASE = ADV_ADDR ? `BSL_RAM_BASE_A : `BSL_RAM_BASE_N;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Straps are captured at the first edge after release
  a_mode_user: assert property (
    $rose(rst_n_i) && !test_strap_i && irq_strap_i |=> mode_o == `BSL_MODE_USER)
    else $error("user mode not selected");
  a_mode_boot: assert property (
    $rose(rst_n_i) && !test_strap_i && !irq_strap_i && boot_select_strap_i
    |=> mode_o == `BSL_MODE_BOOT) else $error("boot mode not selected");
  a_mode_prog: assert property (
    $rose(rst_n_i) && test_strap_i && !programmer_strap_0_i && !programmer_strap_1_i
    && !programmer_strap_2_i |=> mode_o == `BSL_MODE_PROG) else $error("prog mode missed");
  a_user_quiet: assert property (
    mode_o == `BSL_MODE_USER |-> !boot_active_o) else $error("loader busy in user mode");
  // Stores stay inside the program window, one pulse per byte
  a_ram_window: assert property (
    ram_we_o |-> (ram_addr_o - BASE) < `BSL_RAM_SIZE) else $error("store outside window");
  a_ram_pulse: assert property (
    ram_we_o |=> !ram_we_o) else $error("store strobe too long");
  a_branch_addr: assert property (
    branch_o |-> branch_addr_o == BASE ##1 !branch_o [*4]) else $error("bad branch");
  a_branch_pin: assert property (
    branch_o |-> ##[0:3] (txd_o && txd_oe_o)) else $error("tx pin not high after branch");
  a_erase_hold: assert property (
    erase_req_o && !erase_done_i && !wdt_ovf_i |=> erase_req_o)
    else $error("erase request dropped");
  a_wdt_end: assert property (
    wdt_ovf_i |-> ##[1:3] !boot_active_o) else $error("watchdog did not end boot");
endmodule

bind bsl_top bsl_top_chk #(.ADV_ADDR(ADV_ADDR)) u_bsl_top_chk (.*);
`default_nettype wire

//--- dv/bsl_host.sv
// Host model on the boot serial link: sends and receives 8N1 frames.
// Assumes the line it watches already folds in the board pull-up.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Serial host
module bsl_host #(
  parameter int BIT = 20
) (
  input wire logic mclk_i,
  input wire logic line_i,
  output logic rxd_o
);
  initial rxd_o = 1'b1;

  // start, 8 data LSB first, one stop, no parity
  // bit time scaled down from 9600 bps to keep runs short
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    begin
      f = {1'b1, b, 1'b0};
      @(posedge mclk_i);
      for (int i = 0; i < 10; i++) begin
        rxd_o <= f[i];
        repeat (BIT) @(posedge mclk_i);
      end
    end
  endtask

  // mid-bit sampling, stop bit returned in bit 8
  task automatic recv(output logic [8:0] r);
    begin
      @(posedge mclk_i);
      while (line_i) @(posedge mclk_i);
      repeat (BIT / 2) @(posedge mclk_i);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge mclk_i);
        r[i] = line_i;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- dv/bsl_top_tb.sv
// Self-checking bench for the boot loader: strap table, then boot scenarios.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "bsl_regs.vh"

// ==========================================================
// Bench top
module bsl_top_tb;
  localparam int BIT = 20;
  logic mclk_i = 0, rst_n_i = 0, wdt_ovf_i = 0, rxd_i;
  logic test_strap_i = 0, irq_strap_i = 1, boot_select_strap_i = 0;
  logic programmer_strap_0_i = 1, programmer_strap_1_i = 1, programmer_strap_2_i = 1;
  logic flash_blank_i = 0, erase_done_i = 0, erase_fail_i = 0;
  logic txd_o, txd_oe_o, erase_req_o, ram_we_o, branch_o, boot_active_o;
  logic [23:0] ram_addr_o, branch_addr_o;
  logic [7:0] ram_wdata_o;
  logic [1:0] mode_o, s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [8:0] r9;
  logic [31:0] ram_q[$];
  logic [7:0] prog [3] = '{8'ha5, 8'h3c, 8'h0f};
  // Strap rows: test, irq, boot, prog0..2, then expected mode
  logic [7:0] rows [6] = '{8'h5d, 8'h3e, 8'h83, 8'he3, 8'h00, 8'h90};
  int errors = 0, tests_run = 0, n_erase = 0, n_br = 0;

  always #5 mclk_i = ~mclk_i;

  bsl_top u_bsl_top (.*);
  // Released transmit pin reads high through the board pull-up
  bsl_host #(.BIT(BIT)) u_bsl_host (
    .mclk_i(mclk_i),
    .line_i(txd_oe_o ? txd_o : 1'b1),
    .rxd_o(rxd_i)
  );

  // Flash stand-in answers an erase one cycle later; stores and branches are logged
  always @(posedge mclk_i) begin
    erase_done_i <= erase_req_o && !erase_done_i;
    if (erase_req_o && !erase_done_i) n_erase <= n_erase + 1;
    if (ram_we_o) ram_q.push_back({ram_addr_o, ram_wdata_o});
    if (branch_o) n_br <= n_br + 1;
  end

  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    begin
      tests_run++;
      if (got !== exp) begin
        errors++;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task close_out;
    begin
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask

  // straps change only while reset is held
  task automatic do_reset(input logic [5:0] s, input int n);
    begin
      @(posedge mclk_i);
      rst_n_i <= 0;
      {test_strap_i, irq_strap_i, boot_select_strap_i} <= s[5:3];
      {programmer_strap_0_i, programmer_strap_1_i, programmer_strap_2_i} <= s[2:0];
      repeat (n) @(posedge mclk_i);
      rst_n_i <= 1;
    end
  endtask

  // Write offers address and data together; each drops once taken
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    begin
      @(posedge mclk_i);
      s_axi_awvalid <= 1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1;
      s_axi_wdata <= d;
      s_axi_bready <= 1;
      do begin
        @(posedge mclk_i);
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      rr = s_axi_bresp;
      s_axi_bready <= 0;
    end
  endtask

  task automatic axr(input logic [31:0] a);
    begin
      @(posedge mclk_i);
      s_axi_arvalid <= 1;
      s_axi_araddr <= a;
      s_axi_rready <= 1;
      do begin
        @(posedge mclk_i);
        if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 0;
    end
  endtask

  // Idle a bit time so the device finishes its stop bit, then send and catch the reply
  task automatic xfer(input logic [7:0] t, input logic [7:0] e);
    logic [8:0] r;
    begin
      repeat (BIT) @(posedge mclk_i);
      fork
        u_bsl_host.send(t);
        u_bsl_host.recv(r);
      join
      ck(r, {1'b1, e});
    end
  endtask

  // Boot entry: an early frame inside the start-up wait is not measured
  task automatic boot_start(input logic blank, input logic fail);
    begin
      flash_blank_i <= blank;
      erase_fail_i <= fail;
      do_reset(6'h0f, 20);
      ram_q.delete();
      n_erase = 0;
      n_br = 0;
      u_bsl_host.send(8'h00);
      xfer(8'h00, `BSL_CODE_ADJ);
      axr(`BSL_OFF_BAUD);
      ck(rd, BIT);
    end
  endtask

  initial begin
    do_reset(6'h17, 8);
    // Strap table
    foreach (rows[i]) begin
      do_reset(rows[i][7:2], 20);
      repeat (2) @(posedge mclk_i);
      ck(mode_o, rows[i][1:0]);
    end
    // User mode register access, unmapped address refused
    do_reset(6'h17, 20);
    axr(`BSL_OFF_CTRL);
    ck(rd, 0);
    axw(`BSL_OFF_CTRL, 32'h6);
    axr(`BSL_OFF_CTRL);
    ck(rd, 32'h6);
    ck(txd_oe_o, 1);
    axw(32'h14, 32'h1);
    ck(rr, 2'h2);
    axr(32'h14);
    ck({rr, rd}, {2'h2, 32'h0});
    // Full load of three bytes into written flash
    boot_start(0, 0);
    xfer(`BSL_CODE_SYNC, `BSL_CODE_OK);
    ck(n_erase, 1);
    xfer(8'h00, 8'h00);
    xfer(8'h03, 8'h03);
    for (int i = 0; i < 3; i++) xfer(prog[i], prog[i]);
    ck(n_br, 0);
    u_bsl_host.recv(r9);
    ck(r9, {1'b1, `BSL_CODE_OK});
    // loaded code not modelled
    // Rest of the stop bit, hand-back to the sequencer, then the logged pulse
    repeat (16) @(posedge mclk_i);
    ck(n_br, 1);
    ck(ram_q.size(), 3);
    for (int i = 0; i < 3; i++) ck(ram_q[i], {24'(`BSL_RAM_BASE_N + i), prog[i]});
    axr(`BSL_OFF_CTRL);
    ck(rd, 32'hc);
    axr(`BSL_OFF_BAUD);
    ck(rd, BIT);
    ck({txd_o, txd_oe_o}, 2'h3);
    // Blank flash needs no erase; oversize length is refused
    boot_start(1, 0);
    xfer(`BSL_CODE_SYNC, `BSL_CODE_OK);
    ck(n_erase, 0);
    xfer(8'h07, 8'h07);
    xfer(8'h71, 8'h71);
    u_bsl_host.recv(r9);
    ck(r9, {1'b1, `BSL_CODE_ERR});
    // Failed erase answers with the error code
    boot_start(0, 1);
    xfer(`BSL_CODE_SYNC, `BSL_CODE_ERR);
    // Watchdog overflow in mid-sequence
    boot_start(0, 0);
    ck(boot_active_o, 1);
    wdt_ovf_i <= 1;
    @(posedge mclk_i);
    wdt_ovf_i <= 0;
    repeat (3) @(posedge mclk_i);
    ck(boot_active_o, 0);
    close_out();
  end

  // Hang guard, sized well past the expected run
  initial begin
    #400000;
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
